/* File: hw/sp_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the serial port
// Assumes: Register indices are multiplied by four to form Wishbone byte addresses
// Notes: Definitions only
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SP_IDX_CONTROL 8'h98
`define SP_IDX_DATA 8'h99
`define SP_IDX_RELOAD_LOW 8'hAA
`define SP_IDX_RELOAD_HIGH 8'hBA
`define SP_IDX_BAUD_SOURCE 8'hD8
`define SP_IDX_POWER_CONTROL 8'hC7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SP_BIT_MODE_HI 7
`define SP_BIT_MODE_LO 6
`define SP_BIT_MULTIPROC 5
`define SP_BIT_RX_ENABLE 4
`define SP_BIT_TX_NINTH 3
`define SP_BIT_RX_NINTH 2
`define SP_BIT_TX_DONE 1
`define SP_BIT_RX_DONE 0
`define SP_BIT_BAUD_SOURCE 7
`define SP_BIT_RATE_DOUBLE 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SP_RST_CONTROL 8'h00
`define SP_RST_DATA 8'h00
`define SP_RST_RELOAD_LOW 8'hD9
`define SP_RST_RELOAD_HIGH 2'h3
`define SP_RST_BAUD_SOURCE 1'h0
`define SP_RST_RATE_DOUBLE 1'h0

// ----------------------------------------
// Clock period in ns; shift counts in processor clock cycles; tick counts in tick16 pulses
// ----------------------------------------
`define SP_CLK_PERIOD_NS 10
`define SP_SHIFT_DIV 4'hC
`define SP_SHIFT_LAST 4'hB
`define SP_SHIFT_RISE 4'h6
`define SP_TICK_LAST 4'hF
`define SP_TICK_CENTRE 4'h7
`define SP_RELOAD_TOP 10'h3FF

`endif

/* File: hw/sp_pkg.sv */
// Purpose: Types shared by the serial port files
// Assumes: Constants come from sp_consts.svh
// Notes: Mode codes follow declaration order 00, 01, 10, 11
package sp_pkg;

   // Operating modes of the port
   typedef enum logic [1:0] {
      MODE_SHIFT,
      MODE_UART8,
      MODE_UART9_FIXED,
      MODE_UART9_VAR
   } sp_mode_t;

   // Transmitter states
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_START,
      TX_BITS,
      TX_STOP,
      TX_SHIFT
   } sp_tx_state_t;

   // Receiver states
   typedef enum logic [2:0] {
      RX_IDLE,
      RX_START,
      RX_BITS,
      RX_STOP,
      RX_SHIFT
   } sp_rx_state_t;

endpackage

/* File: hw/sp_baud_gen.sv */
// Purpose: Bit-rate ticks for the serial port, all from the processor clock
// Assumes: timer1Overflow is a one-cycle pulse from logic on clk
// Notes: tick16 runs at sixteen times the bit rate; shift clock edges at clk / 12
`timescale 1ns/10ps
`include "sp_consts.svh"
module sp_baud_gen
   import sp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] modeSel,
   input wire logic rateDouble,
   input wire logic baudSourceSelect,
   input wire logic [9:0] baudReloadValue,
   input wire logic timer1Overflow,
   output logic tick16,
   output logic shiftFall,
   output logic shiftRise
);

   logic prePhase_reg, prePhase_next;
   logic [9:0] relCnt_reg, relCnt_next;
   logic halfPhase_reg, halfPhase_next;
   logic [3:0] shiftCnt_reg, shiftCnt_next;
   logic tick_reg, tick_next;
   logic fall_reg, fall_next;
   logic rise_reg, rise_next;
   logic relOvf;
   logic srcPulse;

   // ----------------------------------------
   // Dividers
   // ----------------------------------------

   // Prescale by two, reload counter, source select, final halving
   always_comb begin
      prePhase_next = ~prePhase_reg;
      relCnt_next = relCnt_reg;
      relOvf = 1'b0;
      if (prePhase_reg) begin
         if (relCnt_reg == `SP_RELOAD_TOP) begin
            relCnt_next = baudReloadValue;
            relOvf = 1'b1;
         end else begin
            relCnt_next = relCnt_reg + 10'h001;
         end
      end
      case (sp_mode_t'(modeSel))
         MODE_UART9_FIXED: srcPulse = prePhase_reg; // clk/64 or clk/32
         MODE_UART8, MODE_UART9_VAR: begin
            srcPulse = baudSourceSelect ? relOvf : timer1Overflow;
         end
         default: srcPulse = 1'b0;
      endcase
      halfPhase_next = srcPulse ? ~halfPhase_reg : halfPhase_reg;
      tick_next = srcPulse & (rateDouble | halfPhase_reg);
      shiftCnt_next = (shiftCnt_reg == `SP_SHIFT_LAST) ? 4'h0 : shiftCnt_reg + 4'h1;
      fall_next = (shiftCnt_reg == 4'h0);
      rise_next = (shiftCnt_reg == `SP_SHIFT_RISE);
   end

   // Register the dividers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prePhase_reg <= 1'b0;
         relCnt_reg <= 10'h000;
         halfPhase_reg <= 1'b0;
         shiftCnt_reg <= 4'h0;
         tick_reg <= 1'b0;
         fall_reg <= 1'b0;
         rise_reg <= 1'b0;
      end else begin
         prePhase_reg <= prePhase_next;
         relCnt_reg <= relCnt_next;
         halfPhase_reg <= halfPhase_next;
         shiftCnt_reg <= shiftCnt_next;
         tick_reg <= tick_next;
         fall_reg <= fall_next;
         rise_reg <= rise_next;
      end
   end

   assign tick16 = tick_reg;
   assign shiftFall = fall_reg;
   assign shiftRise = rise_reg;

endmodule // sp_baud_gen

/* File: hw/sp_serial_port.sv */
// Purpose: Four-mode serial port with Wishbone classic register access
// Assumes: clk is the processor clock; rxdPin is asynchronous
// Notes: Registers sit at byte address 4 * index; unmapped reads return zero
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/10ps
`include "sp_consts.svh"
module sp_serial_port
   import sp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   input wire logic timer1Overflow,
   input wire logic rxdPin,
   output logic rxdOut,
   output logic rxdOe,
   output logic txdOut
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic ack_reg, ack_next;
   logic [31:0] datO_reg, datO_next;
   logic [1:0] mode_reg, mode_next;
   logic multiproc_reg, multiproc_next;
   logic rxEnable_reg, rxEnable_next;
   logic txNinth_reg, txNinth_next;
   logic rxNinth_reg, rxNinth_next;
   logic txDone_reg, txDone_next;
   logic rxDone_reg, rxDone_next;
   logic [7:0] rxBuf_reg, rxBuf_next;
   logic [7:0] relLow_reg, relLow_next;
   logic [1:0] relHigh_reg, relHigh_next;
   logic baudSrc_reg, baudSrc_next;
   logic rateDouble_reg, rateDouble_next;
   logic sync1_reg, sync2_reg, sync3_reg, rxdIn_reg, rxdIn_next;
   sp_tx_state_t txState_reg, txState_next;
   logic [8:0] txShift_reg, txShift_next;
   logic [3:0] txBit_reg, txBit_next;
   logic [3:0] txTick_reg, txTick_next;
   logic shiftLow_reg, shiftLow_next;
   logic txd_reg, txd_next;
   logic rxdOut_reg, rxdOut_next;
   logic rxdOe_reg, rxdOe_next;
   sp_rx_state_t rxState_reg, rxState_next;
   logic [8:0] rxShift_reg, rxShift_next;
   logic [3:0] rxBit_reg, rxBit_next;
   logic [3:0] rxTick_reg, rxTick_next;
   logic busReq, busWrite;
   logic [7:0] regIdx;
   logic [7:0] wrByte;
   logic txStart, txDoneSet, rxDoneSet, rxLoad, rxNinthLoad;
   logic [7:0] rxLoadData;
   logic rxNinthVal;
   logic nineBit;
   logic tick16, shiftFall, shiftRise;

   assign regIdx = wbAdr[9:2];
   assign wrByte = wbDatI[7:0];
   assign busReq = wbCyc & wbStb & ~ack_reg;
   assign busWrite = busReq & wbWe & wbSel[0];
   assign txStart = busWrite && (regIdx == `SP_IDX_DATA);
   assign nineBit = mode_reg[1];

   // ----------------------------------------
   // Baud generator
   // ----------------------------------------
   sp_baud_gen u_baud (
      .clk(clk),
      .resetn(resetn),
      .modeSel(mode_reg),
      .rateDouble(rateDouble_reg),
      .baudSourceSelect(baudSrc_reg),
      .baudReloadValue({relHigh_reg, relLow_reg}),
      .timer1Overflow(timer1Overflow),
      .tick16(tick16),
      .shiftFall(shiftFall),
      .shiftRise(shiftRise)
   );

   // ----------------------------------------
   // Receive pin synchroniser
   // ----------------------------------------

   // Level accepted once second and third stages agree
   always_comb begin
      rxdIn_next = (sync2_reg == sync3_reg) ? sync3_reg : rxdIn_reg;
   end

   // Three stage pin capture
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
         rxdIn_reg <= 1'b1;
      end else begin
         sync1_reg <= rxdPin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         rxdIn_reg <= rxdIn_next;
      end
   end

   // ----------------------------------------
   // Register file and Wishbone slave
   // ----------------------------------------

   // Decode, read mux and flag updates; hardware set beats software clear
   always_comb begin
      ack_next = busReq;
      datO_next = datO_reg;
      mode_next = mode_reg;
      multiproc_next = multiproc_reg;
      rxEnable_next = rxEnable_reg;
      txNinth_next = txNinth_reg;
      rxNinth_next = rxNinth_reg;
      txDone_next = txDone_reg;
      rxDone_next = rxDone_reg;
      relLow_next = relLow_reg;
      relHigh_next = relHigh_reg;
      baudSrc_next = baudSrc_reg;
      rateDouble_next = rateDouble_reg;
      if (busReq) begin
         case (regIdx)
            `SP_IDX_CONTROL: begin
               datO_next = {24'h000000, mode_reg, multiproc_reg, rxEnable_reg,
                            txNinth_reg, rxNinth_reg, txDone_reg, rxDone_reg};
            end
            `SP_IDX_DATA: datO_next = {24'h000000, rxBuf_reg};
            `SP_IDX_RELOAD_LOW: datO_next = {24'h000000, relLow_reg};
            `SP_IDX_RELOAD_HIGH: datO_next = {30'h00000000, relHigh_reg};
            `SP_IDX_BAUD_SOURCE: datO_next = {24'h000000, baudSrc_reg, 7'h00};
            `SP_IDX_POWER_CONTROL: datO_next = {24'h000000, rateDouble_reg, 7'h00};
            default: datO_next = 32'h00000000;
         endcase
      end
      if (busWrite) begin
         case (regIdx)
            `SP_IDX_CONTROL: begin
               mode_next = {wrByte[`SP_BIT_MODE_HI], wrByte[`SP_BIT_MODE_LO]};
               multiproc_next = wrByte[`SP_BIT_MULTIPROC];
               rxEnable_next = wrByte[`SP_BIT_RX_ENABLE];
               txNinth_next = wrByte[`SP_BIT_TX_NINTH];
               rxNinth_next = wrByte[`SP_BIT_RX_NINTH];
               txDone_next = wrByte[`SP_BIT_TX_DONE];
               rxDone_next = wrByte[`SP_BIT_RX_DONE];
            end
            `SP_IDX_RELOAD_LOW: relLow_next = wrByte;
            `SP_IDX_RELOAD_HIGH: relHigh_next = wrByte[1:0];
            `SP_IDX_BAUD_SOURCE: baudSrc_next = wrByte[`SP_BIT_BAUD_SOURCE];
            `SP_IDX_POWER_CONTROL: rateDouble_next = wrByte[`SP_BIT_RATE_DOUBLE];
            default: ;
         endcase
      end
      if (txDoneSet) txDone_next = 1'b1;
      if (rxDoneSet) rxDone_next = 1'b1;
      if (rxNinthLoad) rxNinth_next = rxNinthVal;
      rxBuf_next = rxLoad ? rxLoadData : rxBuf_reg;
   end

   // Register file storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_reg <= 1'b0;
         datO_reg <= 32'h00000000;
         mode_reg <= 2'(`SP_RST_CONTROL >> `SP_BIT_MODE_LO);
         multiproc_reg <= 1'b0;
         rxEnable_reg <= 1'b0;
         txNinth_reg <= 1'b0;
         rxNinth_reg <= 1'b0;
         txDone_reg <= 1'b0;
         rxDone_reg <= 1'b0;
         rxBuf_reg <= `SP_RST_DATA;
         relLow_reg <= `SP_RST_RELOAD_LOW;
         relHigh_reg <= `SP_RST_RELOAD_HIGH;
         baudSrc_reg <= `SP_RST_BAUD_SOURCE;
         rateDouble_reg <= `SP_RST_RATE_DOUBLE;
      end else begin
         ack_reg <= ack_next;
         datO_reg <= datO_next;
         mode_reg <= mode_next;
         multiproc_reg <= multiproc_next;
         rxEnable_reg <= rxEnable_next;
         txNinth_reg <= txNinth_next;
         rxNinth_reg <= rxNinth_next;
         txDone_reg <= txDone_next;
         rxDone_reg <= rxDone_next;
         rxBuf_reg <= rxBuf_next;
         relLow_reg <= relLow_next;
         relHigh_reg <= relHigh_next;
         baudSrc_reg <= baudSrc_next;
         rateDouble_reg <= rateDouble_next;
      end
   end

   // ----------------------------------------
   // Transmitter and shift clock
   // ----------------------------------------

   // Frame sequencing, shift clock and pin levels
   always_comb begin
      txState_next = txState_reg;
      txShift_next = txShift_reg;
      txBit_next = txBit_reg;
      txTick_next = txTick_reg;
      txDoneSet = 1'b0;
      rxdOut_next = rxdOut_reg;
      shiftLow_next = shiftLow_reg;
      case (txState_reg)
         TX_START, TX_BITS, TX_STOP: begin
            if (tick16) begin
               txTick_next = txTick_reg + 4'h1;
               if (txTick_reg == `SP_TICK_LAST) begin
                  case (txState_reg)
                     TX_START: begin
                        txState_next = TX_BITS;
                        txBit_next = 4'h0;
                     end
                     TX_BITS: begin
                        txShift_next = {1'b1, txShift_reg[8:1]};
                        txBit_next = txBit_reg + 4'h1;
                        if (txBit_reg == (nineBit ? 4'h8 : 4'h7)) begin
                           txState_next = TX_STOP;
                           txDoneSet = 1'b1;
                        end
                     end
                     default: txState_next = TX_IDLE;
                  endcase
               end
            end
         end
         TX_SHIFT: begin
            if (shiftFall) begin
               if (txBit_reg == 4'h8) begin
                  txState_next = TX_IDLE;
                  txDoneSet = 1'b1;
               end else begin
                  rxdOut_next = txShift_reg[0];
               end
            end else if (shiftRise && shiftLow_reg) begin
               txShift_next = {1'b1, txShift_reg[8:1]};
               txBit_next = txBit_reg + 4'h1;
            end
         end
         default: ;
      endcase
      if (txStart) begin
         txShift_next = {txNinth_reg, wrByte};
         txBit_next = 4'h0;
         txTick_next = 4'h0;
         txState_next = (mode_reg == MODE_SHIFT) ? TX_SHIFT : TX_START;
      end
      // Shift clock low phase, shared by both mode 0 directions
      if (shiftFall && ((txState_reg == TX_SHIFT && txBit_reg != 4'h8) ||
                        (rxState_reg == RX_SHIFT && rxBit_reg != 4'h8))) begin
         shiftLow_next = 1'b1;
      end else if (shiftRise) begin
         shiftLow_next = 1'b0;
      end
      rxdOe_next = (txState_next == TX_SHIFT);
      if (mode_reg == MODE_SHIFT) begin
         txd_next = ~shiftLow_next;
      end else begin
         case (txState_next)
            TX_START: txd_next = 1'b0;
            TX_BITS: txd_next = txShift_next[0];
            default: txd_next = 1'b1;
         endcase
      end
   end

   // Transmitter storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txState_reg <= TX_IDLE;
         txShift_reg <= 9'h1FF;
         txBit_reg <= 4'h0;
         txTick_reg <= 4'h0;
         shiftLow_reg <= 1'b0;
         txd_reg <= 1'b1;
         rxdOut_reg <= 1'b1;
         rxdOe_reg <= 1'b0;
      end else begin
         txState_reg <= txState_next;
         txShift_reg <= txShift_next;
         txBit_reg <= txBit_next;
         txTick_reg <= txTick_next;
         shiftLow_reg <= shiftLow_next;
         txd_reg <= txd_next;
         rxdOut_reg <= rxdOut_next;
         rxdOe_reg <= rxdOe_next;
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------

   // Start detection, centre sampling and completion
   always_comb begin
      rxState_next = rxState_reg;
      rxShift_next = rxShift_reg;
      rxBit_next = rxBit_reg;
      rxTick_next = rxTick_reg;
      rxDoneSet = 1'b0;
      rxLoad = 1'b0;
      rxNinthLoad = 1'b0;
      rxNinthVal = rxShift_reg[8];
      rxLoadData = rxShift_reg[7:0];
      case (rxState_reg)
         RX_IDLE: begin
            if (rxEnable_reg && mode_reg != MODE_SHIFT && !rxdIn_reg) begin
               rxState_next = RX_START;
               rxTick_next = 4'h0;
            end else if (rxEnable_reg && mode_reg == MODE_SHIFT && !rxDone_reg &&
                         txState_reg == TX_IDLE) begin
               rxState_next = RX_SHIFT;
               rxBit_next = 4'h0;
            end
         end
         RX_START, RX_BITS, RX_STOP: begin
            if (tick16) begin
               rxTick_next = rxTick_reg + 4'h1;
               if (rxState_reg == RX_START && rxTick_reg == `SP_TICK_CENTRE) begin
                  rxTick_next = 4'h0;
                  rxBit_next = 4'h0;
                  rxState_next = rxdIn_reg ? RX_IDLE : RX_BITS;
               end else if (rxState_reg == RX_BITS && rxTick_reg == `SP_TICK_LAST) begin
                  rxShift_next = {rxdIn_reg, rxShift_reg[8:1]};
                  rxBit_next = rxBit_reg + 4'h1;
                  if (rxBit_reg == (nineBit ? 4'h8 : 4'h7)) rxState_next = RX_STOP;
               end else if (rxState_reg == RX_STOP && rxTick_reg == `SP_TICK_LAST) begin
                  rxState_next = RX_IDLE;
                  if (!rxDone_reg && (!multiproc_reg || !nineBit || rxShift_reg[8])) begin
                     rxDoneSet = 1'b1;
                     rxLoad = 1'b1;
                     rxLoadData = nineBit ? rxShift_reg[7:0] : rxShift_reg[8:1];
                     rxNinthLoad = nineBit;
                  end
               end
            end
         end
         RX_SHIFT: begin
            if (shiftFall && rxBit_reg == 4'h8) begin
               rxState_next = RX_IDLE;
               rxDoneSet = 1'b1;
               rxLoad = 1'b1;
               rxLoadData = rxShift_reg[8:1];
            end else if (shiftRise && shiftLow_reg) begin
               rxShift_next = {rxdIn_reg, rxShift_reg[8:1]};
               rxBit_next = rxBit_reg + 4'h1;
            end
         end
         default: rxState_next = RX_IDLE;
      endcase
      if (!rxEnable_reg) rxState_next = RX_IDLE;
   end

   // Receiver storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxState_reg <= RX_IDLE;
         rxShift_reg <= 9'h000;
         rxBit_reg <= 4'h0;
         rxTick_reg <= 4'h0;
      end else begin
         rxState_reg <= rxState_next;
         rxShift_reg <= rxShift_next;
         rxBit_reg <= rxBit_next;
         rxTick_reg <= rxTick_next;
      end
   end

   assign wbAck = ack_reg;
   assign wbDatO = datO_reg;
   assign txdOut = txd_reg;
   assign rxdOut = rxdOut_reg;
   assign rxdOe = rxdOe_reg;

endmodule // sp_serial_port

/* File: bench/sp_checker.sv */
// Purpose: Bus and line checks on the serial port
// Assumes: Wishbone classic master holds its request until ack
// Notes: Port mode is tracked from acknowledged control writes
`timescale 1ns/10ps
module sp_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [9:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   input wire logic [31:0] wbDatO,
   input wire logic wbAck,
   input wire logic rxdOe,
   input wire logic txdOut
);
   logic [1:0] modeReg;
   wire logic wrOk = wbAck && wbWe && wbSel[0];
   wire logic [7:0] idx = wbAdr[9:2];
   // Mode of the last control write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         modeReg <= 2'h0;
      else if (wrOk && idx == 8'h98)
         modeReg <= wbDatI[7:6];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_ackNext; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
   a_ackNext: assert property (p_ackNext) else $error("ack late");
   property p_ackOnce; wbAck |=> !wbAck; endproperty
   a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
   property p_ackCause; wbAck |-> $past(wbCyc && wbStb); endproperty
   a_ackCause: assert property (p_ackCause) else $error("ack unasked");
   property p_unmapped;
      wbAck && !wbWe && !(idx inside {8'h98, 8'h99, 8'hAA, 8'hBA, 8'hD8, 8'hC7})
         |-> wbDatO == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_highBits; wbAck && !wbWe && idx == 8'hBA |-> wbDatO[31:2] == 30'h0; endproperty
   a_highBits: assert property (p_highBits) else $error("reload high wide");
   property p_tx9Start; wrOk && idx == 8'h99 && modeReg == 2'h2 |-> ##[1:12] !txdOut; endproperty
   a_tx9Start: assert property (p_tx9Start) else $error("no start bit");
   property p_shiftOe; wrOk && idx == 8'h99 && modeReg == 2'h0 |-> ##[1:30] rxdOe; endproperty
   a_shiftOe: assert property (p_shiftOe) else $error("shift pin idle");
   property p_idle; $rose(resetn) |-> txdOut && !rxdOe; endproperty
   a_idle: assert property (p_idle) else $error("line not idle");
endmodule // sp_checker
bind sp_serial_port sp_checker i_chk (.clk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
   .wbDatI, .wbDatO, .wbAck, .rxdOe, .txdOut);

/* File: bench/sp_remote.sv */
// Purpose: Remote serial device on the receive and transmit lines
// Assumes: Bit length is given in processor clocks
// Notes: Frames carry nine data bits
`timescale 1ns/10ps
module sp_remote (
   input wire logic clk,
   input wire logic txdLine,
   output logic rxdLine
);
   initial rxdLine = 1'b1; // Idle mark
   // Start, nine bits LSB first, stop
   task automatic sendFrame(input logic [8:0] d, input int bitClk);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         rxdLine <= f[i];
         repeat (bitClk - 1) @(posedge clk);
      end
   endtask
   // Centre samples of nine bits and stop
   task automatic grabFrame(output logic [9:0] d, input int bitClk);
      @(negedge txdLine);
      repeat (bitClk / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (bitClk) @(posedge clk);
         d[i] = txdLine;
      end
   endtask
endmodule // sp_remote

/* File: bench/tb_top.sv */
// Purpose: Register and frame tests of the serial port
// Assumes: Bus answers within a few cycles
// Notes: Timer overflow pulses every other clock; all four modes exercised
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, resetn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
   logic [9:0] wbAdr = 10'h0;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0, wbDatO, rd;
   logic wbAck, rxdOut, rxdOe, txdOut, remLine;
   logic tmrOvf = 1'b0;
   logic [9:0] fr;
   int fail_count = 0, checked = 0;
   wire logic rxdPin = rxdOe ? rxdOut : remLine;
   always #5 clk = ~clk;
   // Timer overflow stand-in, one pulse every two clocks
   always @(posedge clk) tmrOvf <= ~tmrOvf;
   sp_serial_port i_dut (.clk, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI,
      .wbDatO, .wbAck, .timer1Overflow(tmrOvf), .rxdPin, .rxdOut, .rxdOe, .txdOut);
   sp_remote i_rem (.clk, .txdLine(txdOut), .rxdLine(remLine));
   // One classic cycle, data taken at the ack edge
   task automatic wbCycle(input logic we, input logic [7:0] idx, input logic [7:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbSel <= 4'h1;
      wbDatI <= {24'h0, d};
      @(posedge clk);
      while (wbAck !== 1'b1) @(posedge clk);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rdChk(input logic [7:0] idx, input logic [31:0] e, input string nm);
      wbCycle(1'b0, idx, 8'h0);
      chk(nm, e, rd);
   endtask
   task automatic conclude;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      conclude;
   end
   // Test sequence
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rdChk(8'h98, 32'h00, "control");
      rdChk(8'h99, 32'h00, "rx buffer");
      rdChk(8'hAA, 32'hD9, "reload low");
      rdChk(8'hBA, 32'h03, "reload high");
      rdChk(8'h10, 32'h00, "unmapped");
      wbCycle(1'b1, 8'hBA, 8'hFE);
      rdChk(8'hBA, 32'h02, "reload mask");
      wbCycle(1'b1, 8'h98, 8'h88);
      fork
         i_rem.grabFrame(fr, 64);
         wbCycle(1'b1, 8'h99, 8'hA5);
      join
      chk("frame div64", 32'h3A5, {22'h0, fr});
      rdChk(8'h98, 32'h8A, "tx done");
      i_rem.sendFrame(9'h15A, 64);
      rdChk(8'h98, 32'h8A, "rx off");
      wbCycle(1'b1, 8'h98, 8'h90);
      i_rem.sendFrame(9'h03C, 64);
      rdChk(8'h98, 32'h91, "rx done");
      rdChk(8'h99, 32'h3C, "rx data");
      wbCycle(1'b1, 8'h98, 8'hB0);
      i_rem.sendFrame(9'h0C3, 64);
      rdChk(8'h98, 32'hB0, "mp skip");
      rdChk(8'h99, 32'h3C, "mp keep");
      i_rem.sendFrame(9'h177, 64);
      rdChk(8'h98, 32'hB5, "mp take");
      rdChk(8'h99, 32'h77, "mp data");
      wbCycle(1'b1, 8'hC7, 8'h80);
      wbCycle(1'b1, 8'h98, 8'h80);
      fork
         i_rem.grabFrame(fr, 32);
         wbCycle(1'b1, 8'h99, 8'h3C);
      join
      chk("frame div32", 32'h23C, {22'h0, fr});
      wbCycle(1'b1, 8'h98, 8'hC8);
      fork
         i_rem.grabFrame(fr, 32);
         wbCycle(1'b1, 8'h99, 8'h5A);
      join
      chk("frame timer", 32'h35A, {22'h0, fr});
      wbCycle(1'b1, 8'hAA, 8'hFF);
      wbCycle(1'b1, 8'hBA, 8'h03);
      wbCycle(1'b1, 8'hD8, 8'h80);
      rdChk(8'hD8, 32'h80, "source select");
      rdChk(8'hC7, 32'h80, "rate double");
      wbCycle(1'b1, 8'h98, 8'h40);
      repeat (600) @(posedge clk);
      fork
         i_rem.grabFrame(fr, 32);
         wbCycle(1'b1, 8'h99, 8'h96);
      join
      chk("frame reload", 32'h396, {22'h0, fr});
      wbCycle(1'b1, 8'h98, 8'h00);
      fork
         for (int i = 0; i < 8; i++) begin
            @(posedge txdOut);
            fr[i] = rxdPin;
         end
         wbCycle(1'b1, 8'h99, 8'h81);
      join
      chk("shift out", 32'h81, {24'h0, fr[7:0]});
      repeat (30) @(posedge clk);
      rdChk(8'h98, 32'h02, "shift done");
      wbCycle(1'b1, 8'h98, 8'h10);
      repeat (150) @(posedge clk);
      rdChk(8'h98, 32'h11, "shift rx done");
      rdChk(8'h99, 32'hFF, "shift rx data");
      conclude;
   end
endmodule // tb_top
